/* core/usbsc_ep0_status_ctrl.sv */
// Bus activity, forced line states and endpoint 0 OUT answer logic of a USB engine.
// Function
// - Control register at I/O 0x13 reads and writes, clears on reset, reserved bits zero.
// - Activity flag bit 0 sets whenever the line is not idle (D+ low, D- high).
// - Writing zero clears the activity flag unless the line is non-idle in that cycle; writing one leaves it unchanged.
// - Force-resume bit 1 drives the transmitter to the K state.
// - Force-idle bit 2 drives the transmitter to the J state when force-resume bit 1 is clear.
// - A valid status stage OUT carries DATA1 with zero data bytes.
// - With auto-reply bit 3 set and stall clear, valid status OUT gets ACK, other OUTs STALL.
// - With auto-reply set, OUT data never goes into the FIFO.
// - Auto-reply bit clears whenever endpoint 0 receives a SETUP token.
// - With OUT-accept bit 4 set and stall and auto-reply clear, OUT data goes into the FIFO and gets ACK.
// - With OUT-accept, auto-reply and stall clear, OUT data is dropped and answered with NAK.
// - OUT-accept clears after every SETUP or OUT transaction on endpoint 0.
// - Stall bit 5 of 0x10 STALLs valid OUTs, no FIFO write, clears on SETUP.
// - Toggle updates for OUT only with stall clear and accept or auto-reply set.
// - CRC, PID, stuffing errors or over 8 data bytes get no handshake.
`timescale 1ns/1ns
`include "usbsc_consts.svh"
module usbsc_ep0_status_ctrl #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_b,
   input  wire logic [7:0]            i_io_addr,
   input  wire logic                  i_io_wr,
   input  wire logic                  i_io_rd,
   input  wire logic [7:0]            i_io_wdata,
   output logic      [7:0]            o_io_rdata,
   input  wire logic                  i_usb_dp,
   input  wire logic                  i_usb_dm,
   output logic                       o_usb_dp,
   output logic                       o_usb_dm,
   output logic                       o_usb_oe_b,
   input  wire logic                  i_tok_valid,
   input  wire usbsc_pkg::usbsc_tok_e i_tok_kind,
   input  wire logic                  i_tok_ep0,
   input  wire logic                  i_rx_byte_valid,
   input  wire logic [7:0]            i_rx_byte,
   input  wire logic                  i_pkt_end,
   input  wire logic                  i_pkt_err,
   input  wire logic                  i_pkt_data1,
   output logic                       o_reply_valid,
   output usbsc_pkg::usbsc_reply_e    o_reply,
   output logic                       o_ep0_rx_toggle,
   output logic      [3:0]            o_ep0_rx_count,
   input  wire logic [2:0]            i_fifo_raddr,
   output logic      [7:0]            o_fifo_rdata
);
   // Line state synchroniser; only the second and third stages are compared.
   logic [1:0] line_s1_r, line_s2_r, line_s3_r, line_r, line_nxt;
   logic       act_r, act_nxt;
   logic       force_res_r, force_j_r;
   logic       status_auto_r, status_auto_nxt;
   logic       out_accept_r, out_accept_nxt;
   logic [7:0] ep0_tx_r, ep0_tx_nxt;
   logic       lat_setup_r, lat_stall_r, lat_status_r, lat_accept_r;
   logic [3:0] cnt_r;
   usbsc_pkg::usbsc_state_e state_r;

   wire [1:0] line_agree  = ~(line_s2_r ^ line_s3_r);
   assign     line_nxt    = (line_agree & line_s2_r) | (~line_agree & line_r);
   wire       non_idle    = (line_r != `USBSC_LINE_IDLE);

   wire wr_sc    = i_io_wr && (i_io_addr == `USBSC_ADDR_STATUS_CTRL);
   wire wr_tx    = i_io_wr && (i_io_addr == `USBSC_ADDR_EP0_TX);
   wire ep0_tok  = i_tok_valid && i_tok_ep0;
   wire setup_tok = ep0_tok && (i_tok_kind == usbsc_pkg::USBSC_TOK_SETUP);
   wire out_tok  = ep0_tok && (i_tok_kind == usbsc_pkg::USBSC_TOK_OUT);
   wire pkt_done = (state_r == usbsc_pkg::USBSC_ST_DATA) && i_pkt_end;
   wire stall_bit = ep0_tx_r[`USBSC_BIT_EP0_STALL];

   // Set wins over the software clear so a line event in the write cycle is kept.
   assign act_nxt = non_idle ? 1'b1 :
                    (wr_sc && !i_io_wdata[`USBSC_BIT_ACTIVITY]) ? 1'b0 : act_r;

   assign status_auto_nxt = setup_tok ? 1'b0 :
                            wr_sc ? i_io_wdata[`USBSC_BIT_STATUS_AUTO] : status_auto_r;
   assign out_accept_nxt  = pkt_done ? 1'b0 :
                            wr_sc ? i_io_wdata[`USBSC_BIT_OUT_ACCEPT] : out_accept_r;

   // The stall and IN-enable bits share the SETUP clear; hardware wins.
   wire [7:0] tx_written = wr_tx ? i_io_wdata : ep0_tx_r;
   wire [7:0] tx_clear   = (8'h01 << `USBSC_BIT_EP0_STALL) | (8'h01 << `USBSC_BIT_EP0_IN_EN);
   assign ep0_tx_nxt = setup_tok ? (tx_written & ~tx_clear) : tx_written;

   // Transaction decode at the end of the data packet.
   wire pkt_bad   = i_pkt_err || (cnt_r > `USBSC_MAX_DATA_BYTES);
   wire is_status = i_pkt_data1 && (cnt_r == 4'h0);
   wire out_open  = !lat_stall_r && (lat_accept_r || lat_status_r);
   wire tog_upd   = lat_setup_r || out_open;
   wire cnt_upd   = lat_setup_r || (!lat_stall_r && lat_accept_r) ||
                    (!lat_stall_r && lat_status_r && !pkt_bad);
   wire fifo_ok   = lat_setup_r || (lat_accept_r && !lat_status_r && !lat_stall_r);
   wire fifo_we   = (state_r == usbsc_pkg::USBSC_ST_DATA) && i_rx_byte_valid &&
                    fifo_ok && (cnt_r < `USBSC_MAX_DATA_BYTES);

   usbsc_pkg::usbsc_reply_e reply_sel;
   always_comb begin
      if (lat_setup_r) begin
         reply_sel = usbsc_pkg::USBSC_REP_ACK;
      end else if (lat_stall_r) begin
         reply_sel = usbsc_pkg::USBSC_REP_STALL;
      end else if (lat_status_r) begin
         reply_sel = is_status ? usbsc_pkg::USBSC_REP_ACK
                               : usbsc_pkg::USBSC_REP_STALL;
      end else if (lat_accept_r) begin
         reply_sel = usbsc_pkg::USBSC_REP_ACK;
      end else begin
         reply_sel = usbsc_pkg::USBSC_REP_NAK;
      end
   end

   wire [7:0] sc_read = {3'b000, out_accept_r, status_auto_r, force_j_r, force_res_r, act_r};
   wire [7:0] rd_sel  = (i_io_addr == `USBSC_ADDR_STATUS_CTRL) ? sc_read :
                        (i_io_addr == `USBSC_ADDR_EP0_TX) ? ep0_tx_r : 8'h00;

   // Resume K has priority so a J held from the previous instruction cannot mask it.
   assign o_usb_dp   = force_res_r;
   assign o_usb_dm   = !force_res_r && force_j_r;
   assign o_usb_oe_b = !(force_res_r || force_j_r);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         line_s1_r <= `USBSC_LINE_IDLE;
         line_s2_r <= `USBSC_LINE_IDLE;
         line_s3_r <= `USBSC_LINE_IDLE;
         line_r    <= `USBSC_LINE_IDLE;
      end else begin
         line_s1_r <= {i_usb_dp, i_usb_dm};
         line_s2_r <= line_s1_r;
         line_s3_r <= line_s2_r;
         line_r    <= line_nxt;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         act_r         <= 1'b0;
         force_res_r   <= 1'b0;
         force_j_r     <= 1'b0;
         status_auto_r <= 1'b0;
         out_accept_r  <= 1'b0;
         ep0_tx_r      <= `USBSC_EP0_TX_RESET;
      end else begin
         act_r         <= act_nxt;
         force_res_r   <= wr_sc ? i_io_wdata[`USBSC_BIT_FORCE_RESUME] : force_res_r;
         force_j_r     <= wr_sc ? i_io_wdata[`USBSC_BIT_FORCE_J] : force_j_r;
         status_auto_r <= status_auto_nxt;
         out_accept_r  <= out_accept_nxt;
         ep0_tx_r      <= ep0_tx_nxt;
      end
   end

   // Control bits are latched at the token so a mid-packet write cannot split a decision.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r      <= usbsc_pkg::USBSC_ST_IDLE;
         lat_setup_r  <= 1'b0;
         lat_stall_r  <= 1'b0;
         lat_status_r <= 1'b0;
         lat_accept_r <= 1'b0;
         cnt_r        <= 4'h0;
      end else if (setup_tok || out_tok) begin
         state_r      <= usbsc_pkg::USBSC_ST_DATA;
         lat_setup_r  <= setup_tok;
         lat_stall_r  <= stall_bit;
         lat_status_r <= status_auto_r;
         lat_accept_r <= out_accept_r;
         cnt_r        <= 4'h0;
      end else begin
         unique case (state_r)
            usbsc_pkg::USBSC_ST_IDLE: begin
               state_r <= usbsc_pkg::USBSC_ST_IDLE;
            end
            usbsc_pkg::USBSC_ST_DATA: begin
               if (i_pkt_end) begin
                  state_r <= usbsc_pkg::USBSC_ST_IDLE;
               end else if (i_rx_byte_valid && cnt_r != `USBSC_OVER_COUNT) begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reply_valid   <= 1'b0;
         o_reply         <= usbsc_pkg::USBSC_REP_ACK;
         o_ep0_rx_toggle <= 1'b0;
         o_ep0_rx_count  <= 4'h0;
         o_io_rdata      <= 8'h00;
      end else begin
         o_reply_valid <= pkt_done && !pkt_bad;
         if (pkt_done) begin
            o_reply <= reply_sel;
         end
         if (pkt_done && tog_upd) begin
            o_ep0_rx_toggle <= i_pkt_data1;
         end
         if (pkt_done && cnt_upd) begin
            o_ep0_rx_count <= cnt_r;
         end
         if (i_io_rd) begin
            o_io_rdata <= rd_sel;
         end
      end
   end

   usbsc_fifo_mem #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .i_sys_clk (i_sys_clk),
      .i_we      (fifo_we),
      .i_waddr   (cnt_r[2:0]),
      .i_wdata   (i_rx_byte),
      .i_raddr   (i_fifo_raddr),
      .o_rdata   (o_fifo_rdata)
   );

   property p_activity_set;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      non_idle |=> act_r;
   endproperty
   a_activity_set: assert property (p_activity_set)
      else $error("Activity flag missed a non-idle line.");

   property p_activity_write;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_sc && !non_idle |=> act_r == ($past(act_r) && $past(i_io_wdata[0]));
   endproperty
   a_activity_write: assert property (p_activity_write)
      else $error("Activity flag write behaved wrongly.");

   property p_resume_k;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(force_res_r) |-> o_usb_dp && !o_usb_dm && !o_usb_oe_b;
   endproperty
   a_resume_k: assert property (p_resume_k)
      else $error("Force resume did not drive K.");

   property p_force_j;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      $past(wr_sc && i_io_wdata[2] && !i_io_wdata[1]) |-> !o_usb_dp && o_usb_dm && !o_usb_oe_b;
   endproperty
   a_force_j: assert property (p_force_j)
      else $error("Force J did not drive J.");

   property p_status_reply;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && !pkt_bad && !lat_setup_r && !lat_stall_r && lat_status_r |=>
         o_reply_valid && o_reply == ($past(is_status) ? usbsc_pkg::USBSC_REP_ACK
                                                       : usbsc_pkg::USBSC_REP_STALL);
   endproperty
   a_status_reply: assert property (p_status_reply)
      else $error("Status stage answer is wrong.");

   property p_status_no_write;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      state_r == usbsc_pkg::USBSC_ST_DATA && lat_status_r && !lat_setup_r |-> !fifo_we;
   endproperty
   a_status_no_write: assert property (p_status_no_write)
      else $error("FIFO written during auto-reply.");

   property p_setup_clears;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      setup_tok |=> !status_auto_r && !ep0_tx_r[`USBSC_BIT_EP0_STALL];
   endproperty
   a_setup_clears: assert property (p_setup_clears)
      else $error("SETUP did not clear auto-reply or stall.");

   property p_accept_ack;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && !pkt_bad && !lat_setup_r && !lat_stall_r && !lat_status_r && lat_accept_r
         |=> o_reply_valid && o_reply == usbsc_pkg::USBSC_REP_ACK && !out_accept_r;
   endproperty
   a_accept_ack: assert property (p_accept_ack)
      else $error("Accepted OUT not ACKed or accept bit not cleared.");

   property p_nak;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && !pkt_bad && !lat_setup_r && !lat_stall_r && !lat_status_r && !lat_accept_r
         |=> o_reply_valid && o_reply == usbsc_pkg::USBSC_REP_NAK;
   endproperty
   a_nak: assert property (p_nak)
      else $error("Refused OUT not NAKed.");

   property p_stall_out;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && !pkt_bad && !lat_setup_r && lat_stall_r
         |=> o_reply_valid && o_reply == usbsc_pkg::USBSC_REP_STALL;
   endproperty
   a_stall_out: assert property (p_stall_out)
      else $error("Stalled OUT not STALLed.");

   property p_error_silent;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && pkt_bad |=> !o_reply_valid;
   endproperty
   a_error_silent: assert property (p_error_silent)
      else $error("Erroneous packet got a handshake.");

   property p_toggle_hold;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      pkt_done && !tog_upd |=> $stable(o_ep0_rx_toggle);
   endproperty
   a_toggle_hold: assert property (p_toggle_hold)
      else $error("Toggle changed on a closed OUT.");
endmodule : usbsc_ep0_status_ctrl

/* inc/usbsc_consts.svh */
// Offsets, bit positions, reset values and counts of the USB status and control block.
`ifndef USBSC_CONSTS_SVH
`define USBSC_CONSTS_SVH

`define USBSC_ADDR_STATUS_CTRL 8'h13
`define USBSC_ADDR_EP0_TX      8'h10

`define USBSC_BIT_ACTIVITY     0
`define USBSC_BIT_FORCE_RESUME 1
`define USBSC_BIT_FORCE_J      2
`define USBSC_BIT_STATUS_AUTO  3
`define USBSC_BIT_OUT_ACCEPT   4
`define USBSC_BIT_EP0_STALL    5
`define USBSC_BIT_EP0_IN_EN    7

`define USBSC_STATUS_CTRL_RESET 8'h00
`define USBSC_STATUS_CTRL_WMASK 8'h1F
`define USBSC_EP0_TX_RESET      8'h00
`define USBSC_LINE_IDLE         2'h1

`define USBSC_MAX_DATA_BYTES 4'h8
`define USBSC_OVER_COUNT     4'h9

`endif

/* inc/usbsc_pkg.sv */
// Types shared by the USB status and control block.
package usbsc_pkg;
   typedef enum logic [1:0] {USBSC_TOK_OUT, USBSC_TOK_IN, USBSC_TOK_SETUP, USBSC_TOK_OTHER}
      usbsc_tok_e;
   typedef enum logic [1:0] {USBSC_REP_ACK, USBSC_REP_NAK, USBSC_REP_STALL} usbsc_reply_e;
   typedef enum logic {USBSC_ST_IDLE, USBSC_ST_DATA} usbsc_state_e;
endpackage : usbsc_pkg

/* core/usbsc_fifo_mem.sv */
// Small endpoint 0 receive memory with a registered read port.
`timescale 1ns/1ns
module usbsc_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_we,
   input  wire logic [AW-1:0]    i_waddr,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic [AW-1:0]    i_raddr,
   output logic      [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
   end
endmodule : usbsc_fifo_mem

/* tb/usbsc_host_model.sv */
// Behavioural USB host that drives the line pins and the decoded packet strobes.
`timescale 1ns/1ns
module usbsc_host_model (
   input  wire logic             i_sys_clk,
   output logic                  o_dp,
   output logic                  o_dm,
   output logic                  o_tok_valid,
   output usbsc_pkg::usbsc_tok_e o_tok_kind,
   output logic                  o_tok_ep0,
   output logic                  o_byte_valid,
   output logic [7:0]            o_byte,
   output logic                  o_pkt_end,
   output logic                  o_pkt_err,
   output logic                  o_pkt_data1
);
   initial begin
      o_dp = 1'h0;
      o_dm = 1'h1;
      o_tok_valid = 1'h0;
      o_tok_kind = usbsc_pkg::USBSC_TOK_OTHER;
      o_tok_ep0 = 1'h0;
      o_byte_valid = 1'h0;
      o_byte = 8'h00;
      o_pkt_end = 1'h0;
      o_pkt_err = 1'h0;
      o_pkt_data1 = 1'h0;
   end

   task automatic line(input logic dp, input logic dm);
      @(negedge i_sys_clk);
      o_dp = dp;
      o_dm = dm;
   endtask : line

   // Byte, error and DATA1 qualifiers are scrambled once their strobe drops; the token kind is held.
   task automatic xfer(input usbsc_pkg::usbsc_tok_e k, input logic [3:0] n,
                       input logic [7:0] b0, input logic d1, input logic err);
      @(negedge i_sys_clk);
      o_tok_valid = 1'h1;
      o_tok_kind = k;
      o_tok_ep0 = 1'h1;
      for (int i = 0; i < n; i++) begin
         @(negedge i_sys_clk);
         o_tok_valid = 1'h0;
         o_tok_ep0 = 1'h0;
         o_byte_valid = 1'h1;
         o_byte = b0 + 8'(i);
      end
      @(negedge i_sys_clk);
      o_tok_valid = 1'h0;
      o_tok_ep0 = 1'h0;
      o_byte_valid = 1'h0;
      o_byte = ~o_byte;
      o_pkt_end = 1'h1;
      o_pkt_err = err;
      o_pkt_data1 = d1;
      @(negedge i_sys_clk);
      o_pkt_end = 1'h0;
      o_pkt_err = ~err;
      o_pkt_data1 = ~d1;
   endtask : xfer
endmodule : usbsc_host_model

/* tb/testbench.sv */
// Self-checking bench of the endpoint 0 status and control block.
`timescale 1ns/1ns
`include "usbsc_consts.svh"
module testbench;
   localparam logic [7:0] SC = `USBSC_ADDR_STATUS_CTRL;
   localparam logic [7:0] TX = `USBSC_ADDR_EP0_TX;
   localparam usbsc_pkg::usbsc_reply_e ACK = usbsc_pkg::USBSC_REP_ACK;
   localparam usbsc_pkg::usbsc_reply_e NAK = usbsc_pkg::USBSC_REP_NAK;
   localparam usbsc_pkg::usbsc_reply_e STL = usbsc_pkg::USBSC_REP_STALL;
   localparam usbsc_pkg::usbsc_tok_e OUT = usbsc_pkg::USBSC_TOK_OUT;
   localparam usbsc_pkg::usbsc_tok_e SET = usbsc_pkg::USBSC_TOK_SETUP;
   logic clk = 1'h0;
   logic rst_b;
   logic [7:0] io_addr, io_wdata, io_rdata, rx_byte, frd;
   logic io_wr, io_rd, dp, dm, odp, odm, oe_b, tv, t0, bv, pe, perr, pd1, rv, tog;
   logic [3:0] cnt;
   logic [2:0] fra;
   usbsc_pkg::usbsc_tok_e tk;
   usbsc_pkg::usbsc_reply_e rep;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;

   usbsc_host_model host_u (.i_sys_clk(clk), .o_dp(dp), .o_dm(dm), .o_tok_valid(tv),
      .o_tok_kind(tk), .o_tok_ep0(t0), .o_byte_valid(bv), .o_byte(rx_byte),
      .o_pkt_end(pe), .o_pkt_err(perr), .o_pkt_data1(pd1));
   usbsc_ep0_status_ctrl dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_io_addr(io_addr),
      .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
      .i_usb_dp(dp), .i_usb_dm(dm), .o_usb_dp(odp), .o_usb_dm(odm), .o_usb_oe_b(oe_b),
      .i_tok_valid(tv), .i_tok_kind(tk), .i_tok_ep0(t0), .i_rx_byte_valid(bv),
      .i_rx_byte(rx_byte), .i_pkt_end(pe), .i_pkt_err(perr), .i_pkt_data1(pd1),
      .o_reply_valid(rv), .o_reply(rep), .o_ep0_rx_toggle(tog), .o_ep0_rx_count(cnt),
      .i_fifo_raddr(fra), .o_fifo_rdata(frd));

   always #20 clk = ~clk;

   task automatic final_report;
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'h1;
      @(negedge clk);
      io_wr = 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'h1;
      @(negedge clk);
      io_rd = 1'h0;
      @(negedge clk);
      chk(io_rdata, e);
   endtask : rd

   task automatic fifo(input logic [2:0] a, input logic [7:0] e);
      @(negedge clk);
      fra = a;
      repeat (2) @(negedge clk);
      chk(frd, e);
   endtask : fifo

   // The pulse is caught at whichever settled point it lands on.
   task automatic reply(input logic v, input usbsc_pkg::usbsc_reply_e e);
      logic seen;
      logic [1:0] r;
      seen = 1'h0;
      r = 2'h3;
      repeat (3) begin
         if (rv === 1'h1) begin
            seen = 1'h1;
            r = rep;
         end
         @(negedge clk);
      end
      chk({7'h0, seen}, {7'h0, v});
      if (v) chk({6'h0, r}, {6'h0, e});
   endtask : reply

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      rst_b = 1'h0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      io_wr = 1'h0;
      io_rd = 1'h0;
      fra = 3'h0;
      repeat (10) @(negedge clk);
      rst_b = 1'h1;
      rd(SC, 8'h00);
      rd(TX, 8'h00);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      wr(SC, 8'h04);
      chk({5'h0, oe_b, odp, odm}, 8'h01);
      wr(SC, 8'h06);
      chk({5'h0, oe_b, odp, odm}, 8'h02);
      rd(SC, 8'h06);
      wr(SC, 8'h00);
      chk({7'h0, oe_b}, 8'h01);
      // A one-cycle glitch never meets the synchroniser's agreement test, so K stands two cycles.
      host_u.line(1'h1, 1'h0);
      host_u.line(1'h1, 1'h0);
      host_u.line(1'h0, 1'h1);
      repeat (6) @(negedge clk);
      rd(SC, 8'h01);
      wr(SC, 8'h01);
      rd(SC, 8'h01);
      wr(SC, 8'h00);
      rd(SC, 8'h00);
      wr(SC, 8'h10);
      host_u.xfer(OUT, 4'h2, 8'h30, 1'h1, 1'h0);
      reply(1'h1, ACK);
      chk({4'h0, cnt}, 8'h02);
      chk({7'h0, tog}, 8'h01);
      rd(SC, 8'h00);
      fifo(3'h1, 8'h31);
      host_u.xfer(OUT, 4'h1, 8'h70, 1'h0, 1'h0);
      reply(1'h1, NAK);
      chk({7'h0, tog}, 8'h01);
      fifo(3'h0, 8'h30);
      wr(SC, 8'h08);
      host_u.xfer(OUT, 4'h0, 8'h00, 1'h1, 1'h0);
      reply(1'h1, ACK);
      host_u.xfer(OUT, 4'h0, 8'h00, 1'h0, 1'h0);
      reply(1'h1, STL);
      chk({7'h0, tog}, 8'h00);
      host_u.xfer(OUT, 4'h1, 8'h90, 1'h1, 1'h0);
      reply(1'h1, STL);
      fifo(3'h0, 8'h30);
      rd(SC, 8'h08);
      host_u.xfer(SET, 4'h0, 8'h00, 1'h0, 1'h0);
      reply(1'h1, ACK);
      rd(SC, 8'h00);
      wr(TX, 8'h20);
      wr(SC, 8'h10);
      host_u.xfer(OUT, 4'h1, 8'hC0, 1'h1, 1'h0);
      reply(1'h1, STL);
      chk({7'h0, tog}, 8'h00);
      fifo(3'h0, 8'h30);
      host_u.xfer(SET, 4'h0, 8'h00, 1'h0, 1'h0);
      reply(1'h1, ACK);
      rd(TX, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(SC, 8'h10);
         host_u.xfer(OUT, (k == 0) ? 4'h1 : 4'h9, 8'hE0, 1'h0, k == 0);
         reply(1'h0, ACK);
      end
      chk({4'h0, cnt}, 8'h09);
      fork
         wr(SC, 8'h18);
         host_u.xfer(SET, 4'h0, 8'h00, 1'h0, 1'h0);
      join
      rd(SC, 8'h00);
      final_report();
   end
endmodule : testbench
